// ---- mode_switch_checker.sv ----
// top of the real/virtual mode switch checker with its AHB-Lite registers
//
// Behaviour
// [RQ1] switch request rising during forced stop is refused with code 0203
// [RQ2] request rising while reset-started servo start runs stores code 0204
// [RQ3] request rising while non-roller axis wants homing: refuse, code 0300
// [RQ4] request rising while any axis shows servo error: refuse, code 0400
// [RQ5] request rising with non-roller unit mismatch stores code 0500
// [RQ6] request rising with cam axis lacking cam data stores code 0600
// [RQ7] request rising with cam number word zero: refuse, code 0800
// [RQ8] cam stroke outside 1 to 2^31-1: refuse, code 0900
// [RQ9] odd cam stroke: refuse, code 0B00
// [RQ10] wrong real mode axis setting: refuse, code 0C00
// [RQ11] in virtual mode, ready flag low or not running: back to real, F002
// [RQ12] in virtual mode, servo error signal change: back to real, F001
// [RQ13] forced stop active: back to real mode, code F000
// [RQ14] codes 0203, 0204, F002, F001, F000 leave axis words untouched
// [RQ15] program homes the axis and re-raises request after homing clears
// [RQ16] checks only on request rise; failure keeps mode and stores code
`timescale 1ns/1ps
module mode_switch_checker
    import mode_switch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic forced_stop_input,
    input wire axis_mask_t axis_servo_error_detected,
    input wire axis_mask_t axis_homing_request,
    output logic irq,
    output logic virtual_mode
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic rd_en;
    logic wr_en;
    logic [`ADDR_W-1:0] wr_addr;
    logic [31:0] rd_value;

    logic [3:0] ctrl;
    axis_mask_t axis_servo_error_reset_cmd;
    logic [31:0] out_cfg;
    logic [15:0] cam_no;
    logic [31:0] cam_stroke;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic [3:0] irq_clr;
    logic [3:0] events;

    err_code_t mode_switch_error_word;
    logic [15:0] error_axis_word_lo;
    logic [15:0] error_axis_word_hi;

    mode_state_t state;
    mode_state_t next_state;
    err_code_t leave_code;
    err_code_t next_leave_code;

    logic req_q;
    logic req_rise;
    logic req_fall;
    axis_mask_t serr_q;
    logic serr_change;
    axis_mask_t rst_cmd_q;
    axis_mask_t start_busy;

    err_code_t chk_code;
    axis_mask_t chk_axes;
    logic chk_axes_valid;

    // ----------------------------------------------------------------
    // bus front end
    // ----------------------------------------------------------------
    mode_switch_ahb_slave u_slave (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rd_en(rd_en),
        .wr_en(wr_en),
        .wr_addr(wr_addr)
    );

    // ----------------------------------------------------------------
    // software-written registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= `CTRL_RESET;
            axis_servo_error_reset_cmd <= '0;
            out_cfg <= `OUT_CFG_RESET;
            cam_no <= `CAM_NO_RESET;
            cam_stroke <= `CAM_STROKE_RESET;
            irq_en <= 4'h0;
        end else if (wr_en) begin
            case (wr_addr)
                `OFF_CTRL: ctrl <= hwdata[3:0];
                `OFF_RESET_CMD: begin
                    axis_servo_error_reset_cmd <= hwdata[`NUM_AXES-1:0];
                end
                `OFF_OUT_CFG: out_cfg <= hwdata;
                `OFF_CAM_NO: cam_no <= hwdata[15:0];
                `OFF_CAM_STROKE: cam_stroke <= hwdata;
                `OFF_IRQ_EN: irq_en <= hwdata[3:0];
                default: ;
            endcase
        end
    end

    // the clear register holds nothing; it is a one-cycle strobe
    assign irq_clr = (wr_en && wr_addr == `OFF_IRQ_CLR) ? hwdata[3:0] : 4'h0;

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb begin
        rd_value = 32'h0000_0000;
        case (haddr[`ADDR_W-1:0])
            `OFF_CTRL: rd_value = {28'h0, ctrl};
            `OFF_RESET_CMD: rd_value = {24'h0, axis_servo_error_reset_cmd};
            `OFF_OUT_CFG: rd_value = out_cfg;
            `OFF_CAM_NO: rd_value = {16'h0, cam_no};
            `OFF_CAM_STROKE: rd_value = cam_stroke;
            `OFF_STATUS: begin
                rd_value = {16'h0, start_busy, 5'h0, state, virtual_mode};
            end
            `OFF_ERR_CODE: rd_value = {16'h0, mode_switch_error_word};
            `OFF_ERR_AXIS: begin
                rd_value = {error_axis_word_hi, error_axis_word_lo};
            end
            `OFF_IRQ_STAT: rd_value = {28'h0, irq_stat};
            `OFF_IRQ_EN: rd_value = {28'h0, irq_en};
            `OFF_AXIS_IN: begin
                rd_value = {15'h0, forced_stop_input, axis_homing_request,
                            axis_servo_error_detected};
            end
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // data is caught at the address edge so the data phase needs no wait
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_en) begin
            hrdata <= rd_value;
        end
    end

    // ----------------------------------------------------------------
    // edge detection on request and axis signals
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_q <= 1'b0;
            serr_q <= '0;
            rst_cmd_q <= '0;
        end else begin
            req_q <= ctrl[`CTRL_REQ];
            serr_q <= axis_servo_error_detected;
            rst_cmd_q <= axis_servo_error_reset_cmd;
        end
    end

    // a request held high across a refusal must drop and rise again
    assign req_rise = ctrl[`CTRL_REQ] & ~req_q; // RQ16 RQ15
    assign req_fall = ~ctrl[`CTRL_REQ] & req_q;
    assign serr_change = |(axis_servo_error_detected ^ serr_q); // RQ12

    // ----------------------------------------------------------------
    // servo start after error reset, per axis
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_AXES; gi = gi + 1) begin : g_start
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    start_busy[gi] <= 1'b0;
                end else if (axis_servo_error_reset_cmd[gi]
                             && !rst_cmd_q[gi]) begin
                    start_busy[gi] <= 1'b1; // RQ2
                end else if (!axis_servo_error_detected[gi]) begin
                    start_busy[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // interlock evaluation
    // ----------------------------------------------------------------
    mode_switch_checks u_checks (
        .forced_stop(forced_stop_input),
        .start_busy(start_busy),
        .homing(axis_homing_request),
        .servo_err(axis_servo_error_detected),
        .roller(out_cfg[7:0]),
        .cam(out_cfg[15:8]),
        .unit_mismatch(out_cfg[23:16]),
        .cam_registered(out_cfg[31:24]),
        .cam_no(cam_no),
        .cam_stroke(cam_stroke),
        .real_axis_ok(ctrl[`CTRL_AXIS_OK]),
        .code(chk_code),
        .axes(chk_axes),
        .axes_valid(chk_axes_valid)
    );

    // ----------------------------------------------------------------
    // mode state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_leave_code = leave_code;
        case (state)
            ST_REAL: begin
                if (req_rise) begin
                    next_state = ST_ENTER; // RQ16
                end
            end
            ST_ENTER: begin
                if (chk_code == `ERR_NONE) begin
                    next_state = ST_VIRTUAL;
                end else begin
                    next_state = ST_REAL; // RQ16
                end
            end
            ST_VIRTUAL: begin
                // forced stop outranks the other return causes
                if (forced_stop_input) begin
                    next_state = ST_LEAVE;
                    next_leave_code = `ERR_RET_STOP; // RQ13
                end else if (serr_change) begin
                    next_state = ST_LEAVE;
                    next_leave_code = `ERR_RET_SERVO; // RQ12
                end else if (!ctrl[`CTRL_READY] || !ctrl[`CTRL_RUN]) begin
                    next_state = ST_LEAVE;
                    next_leave_code = `ERR_RET_READY; // RQ11
                end else if (req_fall) begin
                    next_state = ST_LEAVE;
                    next_leave_code = `ERR_NONE;
                end
            end
            ST_LEAVE: next_state = ST_REAL;
            default: next_state = ST_REAL;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_REAL;
            leave_code <= `ERR_NONE;
        end else begin
            state <= next_state;
            leave_code <= next_leave_code;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            virtual_mode <= 1'b0;
        end else begin
            virtual_mode <= (next_state == ST_VIRTUAL);
        end
    end

    // ----------------------------------------------------------------
    // error words
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_switch_error_word <= `ERR_CODE_RESET;
        end else if (state == ST_ENTER && chk_code != `ERR_NONE) begin
            mode_switch_error_word <= chk_code; // RQ16
        end else if (state == ST_LEAVE && leave_code != `ERR_NONE) begin
            mode_switch_error_word <= leave_code; // RQ11 RQ12 RQ13
        end
    end

    // return codes never reach this block, so the axis words stay put
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            error_axis_word_lo <= 16'h0000;
            error_axis_word_hi <= 16'h0000;
        end else if (state == ST_ENTER && chk_code != `ERR_NONE
                     && chk_axes_valid) begin // RQ14
            error_axis_word_lo <= {8'h00, chk_axes};
            error_axis_word_hi <= 16'h0000;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status, enable and output
    // ----------------------------------------------------------------
    always_comb begin
        events = 4'h0;
        events[`EV_ENTERED] = (state == ST_ENTER) && (chk_code == `ERR_NONE);
        events[`EV_REFUSED] = (state == ST_ENTER) && (chk_code != `ERR_NONE);
        events[`EV_FORCED] = (state == ST_LEAVE) && (leave_code != `ERR_NONE);
        events[`EV_LEFT] = (state == ST_LEAVE) && (leave_code == `ERR_NONE);
    end

    // an event in the clearing cycle survives the clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | events;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & ~irq_clr) | events) & irq_en);
        end
    end

endmodule : mode_switch_checker

// ---- mode_switch_defines.svh ----
// offsets, field positions, reset values and result codes of the mode switch
`ifndef MODE_SWITCH_DEFINES_SVH
`define MODE_SWITCH_DEFINES_SVH

`define NUM_AXES 8
`define ADDR_W 8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_RESET_CMD 8'h04
`define OFF_OUT_CFG 8'h08
`define OFF_CAM_NO 8'h0C
`define OFF_CAM_STROKE 8'h10
`define OFF_STATUS 8'h14
`define OFF_ERR_CODE 8'h18
`define OFF_ERR_AXIS 8'h1C
`define OFF_IRQ_STAT 8'h20
`define OFF_IRQ_EN 8'h24
`define OFF_IRQ_CLR 8'h28
`define OFF_AXIS_IN 8'h2C

// ----------------------------------------------------------------
// control bits and reset values
// ----------------------------------------------------------------
`define CTRL_REQ 0
`define CTRL_READY 1
`define CTRL_RUN 2
`define CTRL_AXIS_OK 3
`define CTRL_RESET 4'h0
`define OUT_CFG_RESET 32'h0000_0000
`define CAM_NO_RESET 16'h0000
`define CAM_STROKE_RESET 32'h0000_0000
`define ERR_CODE_RESET 16'h0000

// ----------------------------------------------------------------
// interrupt event bits
// ----------------------------------------------------------------
`define EV_ENTERED 0
`define EV_REFUSED 1
`define EV_FORCED 2
`define EV_LEFT 3

// ----------------------------------------------------------------
// mode switching error codes
// ----------------------------------------------------------------
`define ERR_NONE 16'h0000
`define ERR_FORCED_STOP 16'h0203
`define ERR_START_BUSY 16'h0204
`define ERR_HOMING 16'h0300
`define ERR_SERVO 16'h0400
`define ERR_UNIT 16'h0500
`define ERR_CAM_DATA 16'h0600
`define ERR_CAM_NO 16'h0800
`define ERR_STROKE_RANGE 16'h0900
`define ERR_STROKE_ODD 16'h0B00
`define ERR_REAL_AXIS 16'h0C00
`define ERR_RET_READY 16'hF002
`define ERR_RET_SERVO 16'hF001
`define ERR_RET_STOP 16'hF000

`endif

// ---- mode_switch_pkg.sv ----
// types shared by the mode switch checker modules
package mode_switch_pkg;
`include "mode_switch_defines.svh"

    typedef enum logic [1:0] {
        ST_REAL = 2'b00,
        ST_ENTER = 2'b01,
        ST_VIRTUAL = 2'b11,
        ST_LEAVE = 2'b10
    } mode_state_t;

    typedef logic [15:0] err_code_t;
    typedef logic [`NUM_AXES-1:0] axis_mask_t;

endpackage : mode_switch_pkg

// ---- mode_switch_ahb_slave.sv ----
// AHB-Lite slave front end: address phase capture and zero-wait answer
`timescale 1ns/1ps
module mode_switch_ahb_slave
    import mode_switch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic rd_en,
    output logic wr_en,
    output logic [`ADDR_W-1:0] wr_addr
);
    logic phase_ok;

    // only whole-word transfers touch the registers
    assign phase_ok = hsel & htrans[1] & hready & (hsize == 3'h2);
    assign rd_en = phase_ok & ~hwrite;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_en <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_en <= phase_ok & hwrite;
            if (phase_ok) begin
                wr_addr <= haddr[`ADDR_W-1:0];
            end
        end
    end

    // every access completes in one data phase with OKAY
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : mode_switch_ahb_slave

// ---- mode_switch_checks.sv ----
// interlock evaluation for a real to virtual switch, in priority order
`timescale 1ns/1ps
module mode_switch_checks
    import mode_switch_pkg::*;
(
    input wire logic forced_stop,
    input wire axis_mask_t start_busy,
    input wire axis_mask_t homing,
    input wire axis_mask_t servo_err,
    input wire axis_mask_t roller,
    input wire axis_mask_t cam,
    input wire axis_mask_t unit_mismatch,
    input wire axis_mask_t cam_registered,
    input wire logic [15:0] cam_no,
    input wire logic [31:0] cam_stroke,
    input wire logic real_axis_ok,
    output err_code_t code,
    output axis_mask_t axes,
    output logic axes_valid
);
    always_comb begin
        code = `ERR_NONE;
        axes = '0;
        axes_valid = 1'b1;
        if (forced_stop) begin
            code = `ERR_FORCED_STOP; // RQ1
            axes_valid = 1'b0; // RQ14
        end else if (|start_busy) begin
            code = `ERR_START_BUSY; // RQ2
            axes_valid = 1'b0; // RQ14
        end else if (|(homing & ~roller)) begin
            code = `ERR_HOMING; // RQ3
            axes = homing & ~roller;
        end else if (|servo_err) begin
            code = `ERR_SERVO; // RQ4
            axes = servo_err;
        end else if (|(unit_mismatch & ~roller)) begin
            code = `ERR_UNIT; // RQ5
            axes = unit_mismatch & ~roller;
        end else if (|(cam & ~cam_registered)) begin
            code = `ERR_CAM_DATA; // RQ6
            axes = cam & ~cam_registered;
        end else if ((|cam) && cam_no == 16'h0000) begin
            code = `ERR_CAM_NO; // RQ7
            axes = cam;
        end else if ((|cam) && (cam_stroke[31] || cam_stroke == 32'h0)) begin
            code = `ERR_STROKE_RANGE; // RQ8
            axes = cam;
        end else if ((|cam) && cam_stroke[0]) begin
            code = `ERR_STROKE_ODD; // RQ9
            axes = cam;
        end else if (!real_axis_ok) begin
            code = `ERR_REAL_AXIS; // RQ10
        end
    end

endmodule : mode_switch_checks

// ---- mode_switch_checker_props.sv ----
// concurrent checks on the ports of the mode switch checker
`timescale 1ns/1ps
module mode_switch_checker_props
    import mode_switch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [31:0] haddr,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic forced_stop_input,
    input wire axis_mask_t axis_servo_error_detected,
    input wire logic virtual_mode
);
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    sequence s_stop_virtual;
        virtual_mode && forced_stop_input;
    endsequence
    sequence s_servo_shift;
        virtual_mode && $changed(axis_servo_error_detected);
    endsequence
    // request bit written to CTRL three edges before the rise
    sequence s_ctrl_rise;
        $past(haddr[7:0], 4) == 8'h00 && $past(hwdata[0], 3);
    endsequence
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_stop_leaves: assert property (
        s_stop_virtual |-> ##[1:2] !virtual_mode)
        else $error("virtual mode kept under forced stop");
    a_servo_leaves: assert property (
        s_servo_shift |-> ##[1:2] !virtual_mode)
        else $error("virtual mode kept after servo error change");
    a_stop_blocks: assert property (
        forced_stop_input && !virtual_mode |=> !virtual_mode)
        else $error("entered virtual mode under forced stop");
    a_servo_blocks: assert property (
        |axis_servo_error_detected && !virtual_mode |=> !virtual_mode)
        else $error("entered virtual mode with servo error");
    a_enter_on_req: assert property (
        $rose(virtual_mode) |-> s_ctrl_rise)
        else $error("virtual mode without request rise");
    a_leave_quiet: assert property (
        $fell(virtual_mode) |-> !virtual_mode [*3])
        else $error("virtual mode back too soon");
    a_resp_okay: assert property (!hresp)
        else $error("bus response not okay");
    a_ready_high: assert property (hreadyout)
        else $error("bus wait state inserted");
endmodule : mode_switch_checker_props

bind mode_switch_checker mode_switch_checker_props mode_switch_checker_props_i (
    .sys_clk(sys_clk), .arst_n(arst_n), .haddr(haddr), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .forced_stop_input(forced_stop_input),
    .axis_servo_error_detected(axis_servo_error_detected),
    .virtual_mode(virtual_mode)
);

// ---- axis_partner.sv ----
// servo axes and user program side: fault, forced stop and homing lines
`timescale 1ns/1ps
module axis_partner
    import mode_switch_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic stop_cmd,
    input wire axis_mask_t fault_cmd,
    input wire axis_mask_t home_cmd,
    output logic forced_stop_input,
    output axis_mask_t axis_servo_error_detected,
    output axis_mask_t axis_homing_request
);
    // lines move only on the clock, like a sampled field input
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            forced_stop_input <= 1'b0;
            axis_servo_error_detected <= 8'h00;
            axis_homing_request <= 8'h00;
        end else begin
            forced_stop_input <= stop_cmd;
            axis_servo_error_detected <= fault_cmd;
            axis_homing_request <= home_cmd;
        end
    end
endmodule : axis_partner

// ---- mode_switch_checker_tb.sv ----
// self-checking bench of the mode switch checker over its register bus
`timescale 1ns/1ps
`include "mode_switch_defines.svh"
module mode_switch_checker_tb;
    import mode_switch_pkg::*;
    logic sys_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic virtual_mode, forced_stop_input, stop_cmd;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] ctl;
    axis_mask_t servo, homing, fault_cmd, home_cmd;
    int mismatches = 0, total_checks = 0;
    logic [31:0] stk [5] = '{32'h0, 32'h3, 32'hFFFF_FFFE, 32'h7FFF_FFFF,
        32'h4};
    logic [15:0] exc [5] = '{`ERR_STROKE_RANGE, `ERR_STROKE_ODD,
        `ERR_STROKE_RANGE, `ERR_STROKE_ODD, `ERR_REAL_AXIS};
    assign hready = hreadyout;
    mode_switch_checker mode_switch_checker_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .forced_stop_input(forced_stop_input),
        .axis_servo_error_detected(servo), .axis_homing_request(homing),
        .irq(irq), .virtual_mode(virtual_mode)
    );
    axis_partner axis_partner_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .stop_cmd(stop_cmd),
        .fault_cmd(fault_cmd), .home_cmd(home_cmd),
        .forced_stop_input(forced_stop_input),
        .axis_servo_error_detected(servo), .axis_homing_request(homing)
    );
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // entered just after a rising edge; leaves read data in d
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1) @(posedge sys_clk);
        d = hrdata;
    endtask : bus
    // all ones as axis value skips the axis word
    task automatic result(input logic [15:0] code, input logic [31:0] ax,
        input logic vm);
        bus(1'b0, `OFF_ERR_CODE, 32'h0);
        check(d, {16'h0000, code});
        if (ax !== 32'hFFFF_FFFF) begin
            bus(1'b0, `OFF_ERR_AXIS, 32'h0);
            check(d, ax);
        end
        check({31'h0, virtual_mode}, {31'h0, vm});
    endtask : result
    task automatic request(input logic [15:0] code, input logic [31:0] ax,
        input logic vm);
        bus(1'b1, `OFF_CTRL, {28'h0000000, ctl});
        bus(1'b1, `OFF_CTRL, {28'h0000000, ctl | 4'h1});
        repeat (4) @(posedge sys_clk);
        result(code, ax, vm);
    endtask : request
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {hsel, hsize, htrans, haddr, hwrite, hwdata} = {1'b1, 3'b010, 67'h0};
        {stop_cmd, fault_cmd, home_cmd, ctl} = {17'h0, 4'h6};
        arst_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, `OFF_OUT_CFG, 32'h0);
        check(d, `OUT_CFG_RESET);
        bus(1'b1, 8'h30, 32'hFFFF_FFFF);
        bus(1'b0, 8'h30, 32'h0);
        check(d, 32'h0);
        bus(1'b1, `OFF_ERR_CODE, 32'h1234);
        bus(1'b0, `OFF_ERR_CODE, 32'h0);
        check(d, {16'h0000, `ERR_CODE_RESET});
        bus(1'b1, `OFF_OUT_CFG, 32'h0002_0400);
        bus(1'b0, `OFF_OUT_CFG, 32'h0);
        check(d, 32'h0002_0400);
        stop_cmd <= 1'b1;
        fault_cmd <= 8'h01;
        home_cmd <= 8'h01;
        @(posedge sys_clk);
        bus(1'b1, `OFF_RESET_CMD, 32'h1);
        request(`ERR_FORCED_STOP, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, `OFF_IRQ_EN, 32'h2);
        bus(1'b0, `OFF_IRQ_STAT, 32'h0);
        check(d, 32'h2);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, `OFF_IRQ_CLR, 32'h2);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0);
        stop_cmd <= 1'b0;
        request(`ERR_START_BUSY, 32'h0, 1'b0);
        fault_cmd <= 8'h00;
        bus(1'b1, `OFF_RESET_CMD, 32'h0);
        request(`ERR_HOMING, 32'h1, 1'b0);
        home_cmd <= 8'h00;
        fault_cmd <= 8'h02;
        request(`ERR_SERVO, 32'h2, 1'b0);
        fault_cmd <= 8'h00;
        request(`ERR_UNIT, 32'h2, 1'b0);
        bus(1'b1, `OFF_OUT_CFG, 32'h0000_0400);
        request(`ERR_CAM_DATA, 32'h4, 1'b0);
        bus(1'b1, `OFF_OUT_CFG, 32'h0400_0400);
        request(`ERR_CAM_NO, 32'hFFFF_FFFF, 1'b0);
        bus(1'b1, `OFF_CAM_NO, 32'h1);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `OFF_CAM_STROKE, stk[i]);
            request(exc[i], (i == 4) ? 32'h0 : '1, 1'b0);
        end
        fault_cmd <= 8'h08;
        request(`ERR_SERVO, 32'h8, 1'b0);
        fault_cmd <= 8'h00;
        ctl = 4'hE;
        request(`ERR_SERVO, 32'h8, 1'b1);
        stop_cmd <= 1'b1;
        repeat (6) @(posedge sys_clk);
        result(`ERR_RET_STOP, 32'h8, 1'b0);
        stop_cmd <= 1'b0;
        request(`ERR_RET_STOP, 32'h8, 1'b1);
        bus(1'b1, `OFF_CTRL, 32'hB);
        repeat (4) @(posedge sys_clk);
        result(`ERR_RET_READY, 32'h8, 1'b0);
        request(`ERR_RET_READY, 32'h8, 1'b1);
        fault_cmd <= 8'h10;
        repeat (6) @(posedge sys_clk);
        result(`ERR_RET_SERVO, 32'h8, 1'b0);
        fault_cmd <= 8'h00;
        request(`ERR_RET_SERVO, 32'h8, 1'b1);
        bus(1'b1, `OFF_CTRL, 32'hD);
        repeat (4) @(posedge sys_clk);
        result(`ERR_RET_READY, 32'h8, 1'b0);
        stop_test;
    end
    // whole sequence needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        stop_test;
    end
endmodule : mode_switch_checker_tb
